// ---- bench/ofc_rx_tb.sv ----
// Self-checking bench of the flow-control receiver.
// Assumes the link model drives the pins; the bench is the bus master.
`timescale 1ns/100ps
module ofc_rx_tb;
  // ********************
  // Signals and parts
  // ********************
  typedef struct packed {
    logic [15:0] cal;
    logic [4:0] st;
    logic sts;
    logic bc;
    logic bs;
  } ofc_row_t;
  logic sysClk, srst, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic linkClk, fcData, fcSync;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] calSeen;
  logic [4:0] expSt;
  ofc_pkg::ofc_app_t app;
  ofc_row_t rows [6];
  ofc_row_t q;
  int n_mismatch, checked, cyc, nCu, nCe, nSu, nSe;

  ofc_rx u_ofc_rx (.sys_clk(sysClk), .srst(srst), .fwd_link_clock(linkClk),
    .serial_fc_line(fcData), .serial_frame_sync(fcSync), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .irq(irq), .appOut(app));
  ofc_tx_model u_ofc_tx_model (.linkClk(linkClk), .fcData(fcData),
    .fcSync(fcSync));
  assign hready = hreadyout;

  initial begin
    sysClk = 1'b0;
    forever #(ofc_pkg::SYS_PERIOD_NS / 2) sysClk = ~sysClk;
  end

  // Strobes are seen with the value they qualify
  always @(posedge sysClk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
    if (app.calUpdate === 1'b1 || app.calError === 1'b1)
      calSeen = app.calendar;
    nCu += (app.calUpdate === 1'b1);
    nCe += (app.calError === 1'b1);
    nSu += (app.stsUpdate === 1'b1);
    nSe += (app.stsError === 1'b1);
  end

  // ********************
  // Tasks
  // ********************
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic end_sim();
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sysClk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sysClk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rst();
    srst <= 1'b1;
    repeat (4) @(posedge sysClk);
    srst <= 1'b0;
    @(posedge sysClk);
  endtask : rst

  task automatic frame(input ofc_row_t r);
    nCu = 0;
    nCe = 0;
    nSu = 0;
    nSe = 0;
    u_ofc_tx_model.send(r.cal, r.st, r.sts, r.bc, r.bs, 0);
    repeat (8) @(posedge sysClk);
  endtask : frame

  task automatic verify(input ofc_row_t r);
    chk(nCu == !r.bc && nCe == r.bc, "cal strobe");
    chk(nSu == (r.sts & !r.bs), "sts update");
    chk(nSe == (r.sts & r.bs), "sts error");
    chk(calSeen === r.cal && app.calendar === r.cal, "calendar");
    chk(app.laneStatus === expSt[4:1], "lanes");
    chk(app.linkStatus === expSt[0], "link");
    bus(1'b0, ofc_pkg::ADDR_CALENDAR, 32'h0);
    chk(rd === {16'h0, r.cal}, "calendar reg");
    bus(1'b0, ofc_pkg::ADDR_LINK_STATE, 32'h0);
    chk(rd === {27'h0, expSt}, "link reg");
  endtask : verify

  // ********************
  // Sequence
  // ********************
  initial begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_mismatch = 0;
    checked = 0;
    cyc = 0;
    expSt = 5'h00;
    rows = '{'{16'hA5C3, 5'h15, 1'b1, 1'b0, 1'b0},
             '{16'hFFFF, 5'h1F, 1'b1, 1'b1, 1'b0},
             '{16'h0000, 5'h0A, 1'b1, 1'b0, 1'b1},
             '{16'h1234, 5'h00, 1'b0, 1'b0, 1'b0},
             '{16'h8001, 5'h0B, 1'b0, 1'b1, 1'b0},
             '{16'h7E81, 5'h13, 1'b1, 1'b1, 1'b1}};
    rst();
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, ofc_pkg::ADDR_CTRL, {30'h0, rows[i].sts, 1'b1});
      if (rows[i].sts)
        expSt = rows[i].st;
      frame(rows[i]);
      verify(rows[i]);
    end
    bus(1'b0, ofc_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(rd === 32'hF && irq === 1'b0, "sticky masked");
    bus(1'b1, ofc_pkg::ADDR_IRQ_MASK, 32'h2);
    bus(1'b0, ofc_pkg::ADDR_IRQ_MASK, 32'h0);
    chk(rd === 32'h2 && irq === 1'b1, "irq raised");
    bus(1'b1, ofc_pkg::ADDR_IRQ_STATUS, 32'h2);
    bus(1'b0, ofc_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(rd === 32'hD && irq === 1'b0, "irq cleared");
    bus(1'b1, ofc_pkg::ADDR_IRQ_MASK, 32'hF);
    bus(1'b1, ofc_pkg::ADDR_IRQ_STATUS, 32'hF);
    bus(1'b0, ofc_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(rd === 32'h0 && irq === 1'b0, "irq all cleared");
    // Disabled receiver ignores a whole frame
    bus(1'b1, ofc_pkg::ADDR_CTRL, 32'h2);
    q = '{16'h5A5A, 5'h1F, 1'b1, 1'b0, 1'b0};
    frame(q);
    chk(nCu + nCe + nSu + nSe == 0, "disabled");
    bus(1'b1, ofc_pkg::ADDR_CTRL, 32'h3);
    // Sync in mid-frame restarts the word
    u_ofc_tx_model.send(16'hFFFF, 5'h00, 1'b1, 1'b0, 1'b0, 7);
    @(posedge sysClk);
    bus(1'b0, ofc_pkg::ADDR_LINK_STATE, 32'h0);
    chk(rd === {25'h0, ofc_pkg::OFC_CAL, expSt}, "phase cal");
    q = '{16'hC0DE, 5'h0C, 1'b1, 1'b0, 1'b0};
    expSt = q.st;
    frame(q);
    verify(q);
    bus(1'b0, ofc_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(rd === 32'h5 && irq === 1'b1, "irq unmasked");
    bus(1'b1, 8'h1C, 32'hF);
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd === 32'h0 && hresp === 1'b0, "unmapped");
    rst();
    chk(irq === 1'b0 && hreadyout === 1'b1 && app === '0, "rst out");
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk(rd === (i == 0 ? 32'h3 : 32'h0), "rst regs");
    end
    end_sim();
  end
endmodule : ofc_rx_tb

// ---- bench/ofc_tx_model.sv ----
// Behavioural upstream sender of the flow-control link.
// Assumes the bench calls send; pins stand still between frames.
`timescale 1ns/100ps
module ofc_tx_model (
  output logic linkClk,
  output logic fcData,
  output logic fcSync
);
  // ********************
  // Frame sender
  // ********************
  localparam int HALF_NS = ofc_pkg::LINK_PERIOD_NS / 2;
  localparam int SKEW_NS = 7; // Keeps link edges off sys clock edges

  function automatic logic [3:0] crc4(input logic [15:0] d, input int n);
    logic [3:0] c;
    logic fb;
    c = ofc_pkg::CRC_INIT;
    for (int i = n - 1; i >= 0; i--) begin
      fb = c[3] ^ d[i];
      c = {c[2:0], 1'b0} ^ (fb ? ofc_pkg::CRC_POLY : 4'h0);
    end
    return c;
  endfunction : crc4

  initial begin
    linkClk = 1'b0;
    fcData = 1'b0;
    fcSync = 1'b0;
  end

  // Bad flags flip one check bit; cut ends the frame early
  task automatic send(input logic [15:0] cal, input logic [4:0] st,
                      input logic sts, bc, bs, input int cut);
    logic [28:0] f;
    int n;
    f = {cal, crc4(cal, 16) ^ {3'h0, bc}, st,
         crc4({11'h0, st}, 5) ^ {3'h0, bs}};
    n = sts ? 29 : 20;
    if (cut > 0)
      n = cut;
    #SKEW_NS;
    for (int i = 0; i < n; i++) begin
      fcData = f[28 - i];
      fcSync = (i == 0);
      #HALF_NS linkClk = 1'b1;
      #HALF_NS linkClk = 1'b0;
    end
    fcSync = 1'b0;
    fcData = ~fcData; // Released line, not the last bit
  endtask : send
endmodule : ofc_tx_model

// ---- rtl/ofc_pkg.sv ----
// Constants and carrier types of the out-of-band flow-control receiver.
// Assumes one system clock; the link pins are sampled, not used as clocks.
package ofc_pkg;

  // ****************************************
  // Link and frame layout
  // ****************************************
  localparam int NUM_LANES = 4;
  localparam int CAL_BITS = 16;
  localparam int CRC_BITS = 4;
  localparam int STS_BITS = NUM_LANES + 1;
  localparam int SHIFT_BITS = CAL_BITS + CRC_BITS + STS_BITS + CRC_BITS;
  // Bit counts: calendar data ends, calendar word ends, status data ends,
  // frame ends
  localparam logic [4:0] CAL_DATA_END = 5'h10;
  localparam logic [4:0] CAL_END = 5'h14;
  localparam logic [4:0] STS_DATA_END = 5'h19;
  localparam logic [4:0] FRAME_END = 5'h1D;
  localparam logic [3:0] CRC_POLY = 4'h3;
  localparam logic [3:0] CRC_INIT = 4'hF;

  // ****************************************
  // Clock rates
  // ****************************************
  localparam int LINK_LIMIT_MHZ = 100;
  localparam int SYS_REC_MHZ = 200;
  localparam int SYS_MHZ = 25;
  localparam int SYS_PERIOD_NS = 1000 / SYS_MHZ;
  localparam int LINK_PERIOD_NS = 320;
  localparam int LINK_CYCLES = LINK_PERIOD_NS / SYS_PERIOD_NS;

  // ****************************************
  // Register map (byte addresses) and fields
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_CALENDAR = 8'h0C;
  localparam logic [7:0] ADDR_LINK_STATE = 8'h10;
  localparam int CTRL_EN = 0;
  localparam int CTRL_STS = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam int IRQ_CAL_UPD = 0;
  localparam int IRQ_CAL_ERR = 1;
  localparam int IRQ_STS_UPD = 2;
  localparam int IRQ_STS_ERR = 3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OFC_IDLE = 2'b00,
    OFC_CAL = 2'b01,
    OFC_STS = 2'b10
  } ofc_phase_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic sync;
  } ofc_pins_t;

  typedef struct packed {
    logic [CAL_BITS-1:0] calendar;
    logic [NUM_LANES-1:0] laneStatus;
    logic linkStatus;
    logic calUpdate;
    logic calError;
    logic stsUpdate;
    logic stsError;
  } ofc_app_t;

endpackage : ofc_pkg

// ---- rtl/ofc_rx.sv ----
// Out-of-band flow-control receiver with an AHB-Lite register slave.
// Assumes an AHB-Lite master on sys_clk and a link clock far below it.
//
// Functional notes
// - Data and sync sampled on link clock
// - Capture runs on faster system clock
// - System clock well above link rate
// - Block cleared by its own reset
// - Lane status vector, one bit per lane
// - One link status bit presented
// - Sixteen-bit calendar value presented
// - Status update strobe on good CRC
// - Status error strobe on bad CRC
// - Calendar update strobe on good CRC
// - Calendar error strobe on bad CRC
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module ofc_rx (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic fwd_link_clock,
  input wire logic serial_fc_line,
  input wire logic serial_frame_sync,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  output ofc_pkg::ofc_app_t appOut
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic linkPrev;
    ofc_pkg::ofc_phase_t phase;
    logic [4:0] bitCnt;
    logic [ofc_pkg::SHIFT_BITS-1:0] shift;
    logic [ofc_pkg::CRC_BITS-1:0] crc;
    ofc_pkg::ofc_app_t app;
    logic [1:0] ctrl;
    logic [3:0] irqSts;
    logic [3:0] irqMask;
    logic dpValid;
    logic dpWrite;
    logic [7:0] dpAddr;
    logic [31:0] rdata;
    logic readyOut;
    logic resp;
    logic irq;
  } ofc_rx_state_t;

  localparam ofc_rx_state_t RESET_STATE = '{
    linkPrev: 1'b0,
    phase: ofc_pkg::OFC_IDLE,
    bitCnt: 5'h00,
    shift: '0,
    crc: ofc_pkg::CRC_INIT,
    app: '0,
    ctrl: ofc_pkg::CTRL_RESET,
    irqSts: 4'h0,
    irqMask: ofc_pkg::MASK_RESET,
    dpValid: 1'b0,
    dpWrite: 1'b0,
    dpAddr: 8'h00,
    rdata: 32'h0000_0000,
    readyOut: 1'b1,
    resp: 1'b0,
    irq: 1'b0
  };

  ofc_rx_state_t r;
  ofc_rx_state_t n;
  ofc_pkg::ofc_pins_t pinRaw;
  ofc_pkg::ofc_pins_t pinS;
  logic linkRise;
  logic calEval;
  logic stsEval;
  logic [4:0] idx;
  logic [4:0] nxt;
  logic [ofc_pkg::SHIFT_BITS-1:0] sh;
  logic [3:0] irqSet;
  logic [3:0] irqClr;

  // One step of CRC-4, data taken MSB first
  function automatic logic [3:0] crc4_step(input logic [3:0] crc,
                                           input logic din);
    logic fb;
    fb = crc[3] ^ din;
    crc4_step = {crc[2:0], 1'b0} ^ (fb ? ofc_pkg::CRC_POLY : 4'h0);
  endfunction : crc4_step

  // ****************************************
  // Pin synchroniser
  // ****************************************
  assign pinRaw = '{clk: fwd_link_clock, data: serial_fc_line,
                    sync: serial_frame_sync};

  ofc_sync2 u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pinIn(pinRaw),
    .pinOut(pinS)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    n = r;
    idx = 5'h00;
    nxt = 5'h00;
    sh = r.shift;
    calEval = 1'b0;
    stsEval = 1'b0;
    irqClr = 4'h0;
    n.app.calUpdate = 1'b0;
    n.app.calError = 1'b0;
    n.app.stsUpdate = 1'b0;
    n.app.stsError = 1'b0;

    // Link edge found by sampling; needs sys clock at least twice link
    n.linkPrev = pinS.clk;
    linkRise = pinS.clk && !r.linkPrev;

    // Frame assembly; a sync mid-frame realigns to a fresh word
    if (!r.ctrl[ofc_pkg::CTRL_EN]) begin
      n.phase = ofc_pkg::OFC_IDLE;
    end else if (linkRise &&
                 (pinS.sync || r.phase != ofc_pkg::OFC_IDLE)) begin
      idx = pinS.sync ? 5'h00 : r.bitCnt;
      nxt = idx + 5'h01;
      sh = {r.shift[ofc_pkg::SHIFT_BITS-2:0], pinS.data};
      n.shift = sh;
      n.bitCnt = nxt;
      n.phase = (idx < ofc_pkg::CAL_END) ? ofc_pkg::OFC_CAL
                                         : ofc_pkg::OFC_STS;
      if (idx < ofc_pkg::CAL_DATA_END) begin
        n.crc = crc4_step((idx == 5'h00) ? ofc_pkg::CRC_INIT : r.crc,
                          pinS.data);
      end else if (idx >= ofc_pkg::CAL_END &&
                   idx < ofc_pkg::STS_DATA_END) begin
        n.crc = crc4_step((idx == ofc_pkg::CAL_END) ? ofc_pkg::CRC_INIT
                                                    : r.crc,
                          pinS.data);
      end
      if (nxt == ofc_pkg::CAL_END) begin
        calEval = 1'b1;
        // Value is shown even when corrupt; the error strobe flags it
        n.app.calendar = sh[ofc_pkg::CRC_BITS +: ofc_pkg::CAL_BITS];
        n.app.calUpdate = (sh[ofc_pkg::CRC_BITS-1:0] == r.crc);
        n.app.calError = (sh[ofc_pkg::CRC_BITS-1:0] != r.crc);
        if (!r.ctrl[ofc_pkg::CTRL_STS]) begin
          n.phase = ofc_pkg::OFC_IDLE;
        end
      end
      if (nxt == ofc_pkg::FRAME_END) begin
        stsEval = 1'b1;
        n.phase = ofc_pkg::OFC_IDLE;
        {n.app.laneStatus, n.app.linkStatus} =
          sh[ofc_pkg::CRC_BITS +: ofc_pkg::STS_BITS];
        n.app.stsUpdate = (sh[ofc_pkg::CRC_BITS-1:0] == r.crc);
        n.app.stsError = (sh[ofc_pkg::CRC_BITS-1:0] != r.crc);
      end
    end

    // Bus data phase: writes
    if (r.dpValid && r.dpWrite) begin
      if (r.dpAddr == ofc_pkg::ADDR_CTRL) begin
        n.ctrl = hwdata[1:0];
      end else if (r.dpAddr == ofc_pkg::ADDR_IRQ_STATUS) begin
        irqClr = hwdata[3:0];
      end else if (r.dpAddr == ofc_pkg::ADDR_IRQ_MASK) begin
        n.irqMask = hwdata[3:0];
      end
    end

    // Sticky events; a set in the clearing cycle survives
    irqSet = {n.app.stsError, n.app.stsUpdate,
              n.app.calError, n.app.calUpdate};
    n.irqSts = (r.irqSts & ~irqClr) | irqSet;
    n.irq = |(n.irqSts & n.irqMask);

    // Bus address phase; always ready, always OKAY
    if (hready) begin
      n.dpValid = hsel && htrans[1];
      n.dpWrite = hwrite;
      n.dpAddr = {haddr[7:2], 2'b00};
      if (hsel && htrans[1] && !hwrite) begin
        // Read uses post-write values so back-to-back access is coherent
        if (haddr[7:0] == ofc_pkg::ADDR_CTRL) begin
          n.rdata = {30'h0000_0000, n.ctrl};
        end else if (haddr[7:0] == ofc_pkg::ADDR_IRQ_STATUS) begin
          n.rdata = {28'h000_0000, n.irqSts};
        end else if (haddr[7:0] == ofc_pkg::ADDR_IRQ_MASK) begin
          n.rdata = {28'h000_0000, n.irqMask};
        end else if (haddr[7:0] == ofc_pkg::ADDR_CALENDAR) begin
          n.rdata = {16'h0000, n.app.calendar};
        end else if (haddr[7:0] == ofc_pkg::ADDR_LINK_STATE) begin
          n.rdata = {25'h000_0000, n.phase, n.app.laneStatus,
                     n.app.linkStatus};
        end else begin
          n.rdata = 32'h0000_0000;
        end
      end
    end
    n.readyOut = 1'b1;
    n.resp = 1'b0;
  end

  // ****************************************
  // Registers
  // ****************************************
  // House reset is synchronous; it loads RESET_STATE into every flop of r, and the synchroniser stages clear to zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r <= RESET_STATE;
    end else begin
      r <= n;
    end
  end

  assign hreadyout = r.readyOut;
  assign hrdata = r.rdata;
  assign hresp = r.resp;
  assign irq = r.irq;
  assign appOut = r.app;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence cal_eval_s;
    linkRise ##0 calEval;
  endsequence

  sequence sts_eval_s;
    linkRise ##0 stsEval;
  endsequence

  sequence quiet_s;
    !appOut.calUpdate && !appOut.calError;
  endsequence

  sequence sync_start_s;
    linkRise ##0 (pinS.sync && r.ctrl[ofc_pkg::CTRL_EN]);
  endsequence

  link_sample_a: assert property (
    !linkRise |=> (r.shift == $past(r.shift)))
    else $error("shift moved without a link edge");

  cal_strobe_a: assert property (
    cal_eval_s |=> (appOut.calUpdate ^ appOut.calError))
    else $error("calendar word gave no single strobe");

  cal_value_a: assert property (
    appOut.calUpdate |->
      appOut.calendar == r.shift[ofc_pkg::CRC_BITS +: ofc_pkg::CAL_BITS])
    else $error("calendar output differs from received word");

  cal_err_crc_a: assert property (
    appOut.calError |-> r.shift[ofc_pkg::CRC_BITS-1:0] != $past(r.crc))
    else $error("calendar error without CRC mismatch");

  cal_once_a: assert property (
    (appOut.calUpdate || appOut.calError) |=> quiet_s [*8])
    else $error("calendar strobe repeated too soon");

  sts_strobe_a: assert property (
    sts_eval_s |=> (appOut.stsUpdate ^ appOut.stsError))
    else $error("status word gave no single strobe");

  sts_gate_a: assert property (
    (appOut.stsUpdate || appOut.stsError) |->
      $past(r.ctrl[ofc_pkg::CTRL_STS]))
    else $error("status strobe while status disabled");

  sts_value_a: assert property (
    appOut.stsUpdate |-> {appOut.laneStatus, appOut.linkStatus} ==
      r.shift[ofc_pkg::CRC_BITS +: ofc_pkg::STS_BITS])
    else $error("status outputs differ from received word");

  sts_err_crc_a: assert property (
    appOut.stsError |-> r.shift[ofc_pkg::CRC_BITS-1:0] != $past(r.crc))
    else $error("status error without CRC mismatch");

  strobe_cause_a: assert property (
    (appOut.calUpdate || appOut.stsUpdate || appOut.calError ||
     appOut.stsError) |-> $past(linkRise))
    else $error("strobe without a link edge");

  irq_raise_a: assert property (
    (appOut.calUpdate && r.irqMask[ofc_pkg::IRQ_CAL_UPD]) |-> irq)
    else $error("masked-in event did not raise interrupt");

  cal_good_crc_a: assert property (
    appOut.calUpdate |-> r.shift[ofc_pkg::CRC_BITS-1:0] == $past(r.crc))
    else $error("calendar update with CRC mismatch");

  sts_good_crc_a: assert property (
    appOut.stsUpdate |-> r.shift[ofc_pkg::CRC_BITS-1:0] == $past(r.crc))
    else $error("status update with CRC mismatch");

  // Values move only with a strobe, so the application never reads a
  // half-built word between strobes
  cal_hold_a: assert property (
    !(appOut.calUpdate || appOut.calError) |->
      $stable(appOut.calendar))
    else $error("calendar changed without a strobe");

  sts_hold_a: assert property (
    !(appOut.stsUpdate || appOut.stsError) |->
      $stable({appOut.laneStatus, appOut.linkStatus}))
    else $error("status changed without a strobe");

  sync_restart_a: assert property (
    sync_start_s |=> (r.bitCnt == 5'h01))
    else $error("sync did not restart the word");

  disabled_quiet_a: assert property (
    !r.ctrl[ofc_pkg::CTRL_EN] |=>
      !(appOut.calUpdate || appOut.calError ||
        appOut.stsUpdate || appOut.stsError))
    else $error("strobe while receiver disabled");

  strobe_pair_a: assert property (
    !(appOut.calUpdate && appOut.calError) &&
    !(appOut.stsUpdate && appOut.stsError))
    else $error("update and error strobes together");

  bus_okay_a: assert property (
    hreadyout && !hresp)
    else $error("bus slave stalled or answered an error");

endmodule : ofc_rx

// ---- rtl/ofc_sync2.sv ----
// Two-stage synchroniser for the three link pins.
// Assumes the pins are asynchronous to sys_clk.
`timescale 1ns/100ps
module ofc_sync2 (
  input wire logic sys_clk,
  input wire logic srst,
  input ofc_pkg::ofc_pins_t pinIn,
  output ofc_pkg::ofc_pins_t pinOut
);

  typedef struct packed {
    ofc_pkg::ofc_pins_t stage1;
    ofc_pkg::ofc_pins_t stage2;
  } ofc_sync_state_t;

  ofc_sync_state_t r;
  ofc_sync_state_t n;

  always_comb begin
    n = r;
    n.stage1 = pinIn;
    n.stage2 = r.stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign pinOut = r.stage2;

endmodule : ofc_sync2
